// ### irq_pkg.sv
// shared constants, types and helpers for the two-level interrupt controller
package irq_pkg;

   // ---------------------------------------------------------------
   // sources, in polling order (index 0 wins among equals)
   // ---------------------------------------------------------------
   localparam int NUM_SRC = 11;
   localparam logic [3:0] SRC_PSM = 4'h0;
   localparam logic [3:0] SRC_WDT = 4'h1;
   localparam logic [3:0] SRC_EXT0 = 4'h2;
   localparam logic [3:0] SRC_ADC = 4'h3;
   localparam logic [3:0] SRC_T0 = 4'h4;
   localparam logic [3:0] SRC_EXT1 = 4'h5;
   localparam logic [3:0] SRC_T1 = 4'h6;
   localparam logic [3:0] SRC_SPI = 4'h7;
   localparam logic [3:0] SRC_UART = 4'h8;
   localparam logic [3:0] SRC_T2 = 4'h9;
   localparam logic [3:0] SRC_TIC = 4'hA;

   // ---------------------------------------------------------------
   // vector addresses
   // ---------------------------------------------------------------
   localparam logic [15:0] VEC_EXT0 = 16'h0003;
   localparam logic [15:0] VEC_T0 = 16'h000B;
   localparam logic [15:0] VEC_EXT1 = 16'h0013;
   localparam logic [15:0] VEC_T1 = 16'h001B;
   localparam logic [15:0] VEC_UART = 16'h0023;
   localparam logic [15:0] VEC_T2 = 16'h002B;
   localparam logic [15:0] VEC_ADC = 16'h0033;
   localparam logic [15:0] VEC_SPI = 16'h003B;
   localparam logic [15:0] VEC_PSM = 16'h0043;
   localparam logic [15:0] VEC_TIC = 16'h0053;
   localparam logic [15:0] VEC_WDT = 16'h005B;
   localparam logic [15:0] VEC_NONE = 16'h0000;

   // ---------------------------------------------------------------
   // secondary enable/priority register
   // ---------------------------------------------------------------
   localparam logic [7:0] SEC_IRQ_ADDR = 8'hA9;
   localparam logic [7:0] SEC_IRQ_RESET = 8'hA0;
   localparam logic [7:0] SFR_READ_IDLE = 8'h00;
   localparam int BIT_EN_SPI = 0;
   localparam int BIT_EN_PSM = 1;
   localparam int BIT_EN_TIC = 2;
   localparam int BIT_LV_SPI = 4;
   localparam int BIT_LV_PSM = 5;
   localparam int BIT_LV_TIC = 6;
   localparam int BIT_UNIMP = 7;
   localparam logic UNIMP_READ = 1'b1;
   localparam logic LEVEL_HIGH = 1'b1;
   localparam logic LEVEL_LOW = 1'b0;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic wdt;
      logic ext0;
      logic adc;
      logic t0;
      logic ext1;
      logic t1;
      logic uart;
      logic t2;
   } prim_bits_t;

   typedef struct packed {
      logic level;
      logic [3:0] src;
      logic [15:0] vector;
   } dispatch_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_PUSH = 2'b01
   } disp_state_t;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [15:0] vector_of(input logic [3:0] src);
      logic [15:0] v;
      unique case (src)
         SRC_PSM: v = VEC_PSM;
         SRC_WDT: v = VEC_WDT;
         SRC_EXT0: v = VEC_EXT0;
         SRC_ADC: v = VEC_ADC;
         SRC_T0: v = VEC_T0;
         SRC_EXT1: v = VEC_EXT1;
         SRC_T1: v = VEC_T1;
         SRC_SPI: v = VEC_SPI;
         SRC_UART: v = VEC_UART;
         SRC_T2: v = VEC_T2;
         SRC_TIC: v = VEC_TIC;
         default: v = VEC_NONE;
      endcase
      return v;
   endfunction

   // lowest set index, i.e. first in polling order
   function automatic logic [3:0] first_set(input logic [NUM_SRC-1:0] req);
      logic [3:0] r;
      r = 4'h0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (req[i]) begin
            r = 4'(i);
         end
      end
      return r;
   endfunction

endpackage

// ### serial_done_tracker.sv
// completion flag of the serial port, set at end of each byte transfer
`timescale 1ns/1ps
module serial_done_tracker
   import irq_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // serial engine status
   input wire logic master_mode,
   input wire logic clock_phase,
   input wire logic master_byte_done,
   input wire logic slave_eighth_clock,
   input wire logic slave_select_n_pin,
   // core side
   input wire logic flag_clear,
   output logic serial_periph_done_flag
);

   // ---------------------------------------------------------------
   // slave-select pin synchroniser
   // ---------------------------------------------------------------
   logic ss_meta;
   logic ss_sync;
   logic ss_late;
   logic ss_stable;
   logic ss_rise;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ss_meta <= 1'b1;
         ss_sync <= 1'b1;
         ss_late <= 1'b1;
      end else begin
         ss_meta <= slave_select_n_pin;
         ss_sync <= ss_meta;
         ss_late <= ss_sync;
      end
   end

   // a level only counts once two stages agree, which filters a single glitch
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ss_stable <= 1'b1;
      end else if (ss_sync == ss_late) begin
         ss_stable <= ss_late;
      end
   end

   assign ss_rise = ss_sync && ss_late && !ss_stable;

   // ---------------------------------------------------------------
   // completion flag
   // ---------------------------------------------------------------
   logic set_evt;

   always_comb begin
      if (master_mode) begin
         set_evt = master_byte_done;
      end else if (clock_phase) begin
         set_evt = slave_eighth_clock;
      end else begin
         set_evt = ss_rise;
      end
   end

   // set wins over a clear in the same cycle
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         serial_periph_done_flag <= 1'b0;
      end else if (set_evt) begin
         serial_periph_done_flag <= 1'b1;
      end else if (flag_clear) begin
         serial_periph_done_flag <= 1'b0;
      end
   end

   master_done_a: assert property (@(posedge mclk) disable iff (rst)
      master_mode && master_byte_done |=> serial_periph_done_flag)
      else $error("master byte end did not set completion flag");

   slave_end_a: assert property (@(posedge mclk) disable iff (rst)
      !master_mode && !clock_phase && ss_rise |=> serial_periph_done_flag)
      else $error("slave select release did not set completion flag");

endmodule

// ### two_level_irq_priority.sv
// two-level interrupt controller with fixed polling order and vectoring
// Behaviour
// - every source has a writable level bit, 1 meaning high and 0 meaning low.
// - a pending high-level request preempts a running low-level service routine.
// - when both levels are pending together the high-level request is dispatched first.
// - while a routine of one level runs no further request of that level is accepted.
// - equal-level ties go by order supply monitor, watchdog, ext0, ADC, t0, ext1, t1, SPI, UART, t2, interval.
// - accepting a request first makes the core push its program counter.
// - ext0, t0, ext1, t1, UART, t2, ADC and SPI vector from 0003H to 003BH in steps of eight.
// - supply monitor vectors to 0043H, interval counter to 0053H, watchdog to 005BH, shared flags share one.
// - secondary register bits 0, 1, 2 enable the SPI, supply monitor and interval counter requests.
// - secondary register bits 4, 5, 6 set the level of SPI, supply monitor and interval counter.
// - bit 7 ignores writes, bit 3 is kept zero by software, and the register resets to A0H.
// - each source is gated by its own enable bit.
// - as master the serial completion flag sets after the eighth clock of a byte.
// - as slave the flag sets after the eighth clock with phase 1, or on select release with phase 0.
`timescale 1ns/1ps
module two_level_irq_priority
   import irq_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // special-function-register bus
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   // primary enable/level bits held by the core
   input wire logic global_enable,
   input wire prim_bits_t primary_enable,
   input wire prim_bits_t primary_level,
   // source flags
   input wire logic supply_monitor_request,
   input wire logic watchdog_request,
   input wire logic external_zero_request,
   input wire logic [1:0] converter_ready_flags,
   input wire logic timer_zero_overflow,
   input wire logic external_one_request,
   input wire logic timer_one_overflow,
   input wire logic two_wire_done_flag,
   input wire logic [1:0] uart_rx_tx_flags,
   input wire logic timer_two_overflow,
   input wire logic timer_two_external_flag,
   input wire logic interval_counter_request,
   // serial engine status
   input wire logic master_mode,
   input wire logic clock_phase,
   input wire logic master_byte_done,
   input wire logic slave_eighth_clock,
   input wire logic slave_select_n_pin,
   input wire logic serial_flag_clear,
   output logic serial_periph_done_flag,
   // core dispatch handshake
   input wire logic core_boundary,
   input wire logic core_reti,
   output logic irq_pending,
   output logic push_pc,
   output logic load_pc,
   output dispatch_t dispatch,
   output logic in_service_high,
   output logic in_service_low
);

   // ---------------------------------------------------------------
   // secondary enable/priority register
   // ---------------------------------------------------------------
   logic [BIT_UNIMP-1:0] secondary_irq_enable_priority;

   // bit 7 has no storage; bit 3 stores what software writes
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         secondary_irq_enable_priority <= SEC_IRQ_RESET[BIT_UNIMP-1:0];
      end else if (sfr_wr && sfr_addr == SEC_IRQ_ADDR) begin
         secondary_irq_enable_priority <= sfr_wdata[BIT_UNIMP-1:0];
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sfr_rdata <= SFR_READ_IDLE;
      end else if (sfr_rd && sfr_addr == SEC_IRQ_ADDR) begin
         sfr_rdata <= {UNIMP_READ, secondary_irq_enable_priority};
      end else begin
         sfr_rdata <= SFR_READ_IDLE;
      end
   end

   // ---------------------------------------------------------------
   // serial completion flag
   // ---------------------------------------------------------------
   serial_done_tracker u_serial_done (
      .mclk(mclk),
      .rst(rst),
      .master_mode(master_mode),
      .clock_phase(clock_phase),
      .master_byte_done(master_byte_done),
      .slave_eighth_clock(slave_eighth_clock),
      .slave_select_n_pin(slave_select_n_pin),
      .flag_clear(serial_flag_clear),
      .serial_periph_done_flag(serial_periph_done_flag)
   );

   // ---------------------------------------------------------------
   // request gating, index = polling position
   // ---------------------------------------------------------------
   logic [NUM_SRC-1:0] src_flag;
   logic [NUM_SRC-1:0] src_enable;
   logic [NUM_SRC-1:0] src_level;
   logic [NUM_SRC-1:0] gated;
   logic [NUM_SRC-1:0] high_req;
   logic [NUM_SRC-1:0] low_req;

   // shared flags of one source merge onto one vector
   assign src_flag = {interval_counter_request, timer_two_overflow | timer_two_external_flag,
                      |uart_rx_tx_flags, serial_periph_done_flag | two_wire_done_flag, timer_one_overflow,
                      external_one_request, timer_zero_overflow, |converter_ready_flags,
                      external_zero_request, watchdog_request, supply_monitor_request};
   assign src_enable = {secondary_irq_enable_priority[BIT_EN_TIC], primary_enable.t2,
                        primary_enable.uart, secondary_irq_enable_priority[BIT_EN_SPI], primary_enable.t1,
                        primary_enable.ext1, primary_enable.t0, primary_enable.adc, primary_enable.ext0,
                        primary_enable.wdt, secondary_irq_enable_priority[BIT_EN_PSM]};
   assign src_level = {secondary_irq_enable_priority[BIT_LV_TIC], primary_level.t2,
                       primary_level.uart, secondary_irq_enable_priority[BIT_LV_SPI], primary_level.t1,
                       primary_level.ext1, primary_level.t0, primary_level.adc, primary_level.ext0,
                       primary_level.wdt, secondary_irq_enable_priority[BIT_LV_PSM]};
   assign gated = src_flag & src_enable & {NUM_SRC{global_enable}};
   assign high_req = gated & src_level;
   assign low_req = gated & ~src_level;

   // ---------------------------------------------------------------
   // arbitration
   // ---------------------------------------------------------------
   logic can_high;
   logic can_low;
   logic have_cand;
   logic cand_level;
   logic [3:0] cand_src;

   assign can_high = !in_service_high && |high_req;
   assign can_low = !in_service_high && !in_service_low && |low_req;
   assign have_cand = can_high || can_low;
   assign cand_level = can_high ? LEVEL_HIGH : LEVEL_LOW;
   assign cand_src = can_high ? first_set(high_req) : first_set(low_req);

   // ---------------------------------------------------------------
   // dispatch sequence: push, then load the vector
   // ---------------------------------------------------------------
   disp_state_t state;
   logic accept;

   assign accept = state == ST_IDLE && core_boundary && have_cand;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state <= ST_IDLE;
      end else begin
         unique case (state)
            ST_IDLE: state <= accept ? ST_PUSH : ST_IDLE;
            ST_PUSH: state <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         push_pc <= 1'b0;
         load_pc <= 1'b0;
      end else begin
         push_pc <= accept;
         load_pc <= state == ST_PUSH;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         dispatch <= '0;
      end else if (accept) begin
         dispatch <= '{level: cand_level, src: cand_src, vector: vector_of(cand_src)};
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         irq_pending <= 1'b0;
      end else begin
         irq_pending <= have_cand;
      end
   end

   // a return ends the innermost routine, which is the high one if both run
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         in_service_high <= 1'b0;
         in_service_low <= 1'b0;
      end else if (state == ST_PUSH) begin
         if (dispatch.level == LEVEL_HIGH) begin
            in_service_high <= 1'b1;
         end else begin
            in_service_low <= 1'b1;
         end
      end else if (core_reti) begin
         if (in_service_high) begin
            in_service_high <= 1'b0;
         end else begin
            in_service_low <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   high_preempts_low_a: assert property (@(posedge mclk) disable iff (rst)
      state == ST_IDLE && core_boundary && in_service_low && !in_service_high && |high_req
      |=> push_pc && dispatch.level == LEVEL_HIGH)
      else $error("high request did not preempt low routine");

   high_first_a: assert property (@(posedge mclk) disable iff (rst)
      accept && |high_req && |low_req && !in_service_high |=> dispatch.level == LEVEL_HIGH)
      else $error("low request dispatched before high");

   same_level_block_a: assert property (@(posedge mclk) disable iff (rst)
      in_service_high && !core_reti && state == ST_IDLE |=> !push_pc)
      else $error("request accepted during high routine");

   poll_order_a: assert property (@(posedge mclk) disable iff (rst)
      accept && gated[SRC_PSM] && (src_level[SRC_PSM] == LEVEL_HIGH || !can_high) |=> dispatch.src == SRC_PSM)
      else $error("polling order not kept");

   push_then_load_a: assert property (@(posedge mclk) disable iff (rst)
      push_pc |=> load_pc ##1 !load_pc)
      else $error("vector load did not follow push");

   ext0_vector_a: assert property (@(posedge mclk) disable iff (rst)
      load_pc && dispatch.src == SRC_EXT0 |-> dispatch.vector == VEC_EXT0)
      else $error("wrong vector for external 0");

   wdt_vector_a: assert property (@(posedge mclk) disable iff (rst)
      load_pc && dispatch.src == SRC_WDT |-> dispatch.vector == VEC_WDT)
      else $error("wrong vector for watchdog");

   global_gate_a: assert property (@(posedge mclk) disable iff (rst)
      !global_enable && state == ST_IDLE |=> !push_pc ##1 !irq_pending || global_enable)
      else $error("request passed with global enable off");

   psm_enable_a: assert property (@(posedge mclk) disable iff (rst)
      accept && !secondary_irq_enable_priority[BIT_EN_PSM] |=> dispatch.src != SRC_PSM)
      else $error("disabled supply monitor dispatched");

   readback_a: assert property (@(posedge mclk) disable iff (rst)
      sfr_rd && sfr_addr == SEC_IRQ_ADDR && !sfr_wr |=> sfr_rdata[BIT_UNIMP] == UNIMP_READ
      && sfr_rdata[BIT_UNIMP-1:0] == $past(secondary_irq_enable_priority))
      else $error("secondary register read back wrong");

endmodule

// ### core_model.sv
// stand-in for the processor core that takes vectors and returns from service routines
`timescale 1ns/1ps
module core_model
   import irq_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // controller side
   input wire logic push_pc,
   input wire logic load_pc,
   input wire dispatch_t dispatch,
   output logic core_boundary,
   output logic core_reti,
   // bench side
   input wire logic run,
   input wire logic ret_req,
   output logic [15:0] pc,
   output logic [3:0] depth,
   output logic seq_err
);
   logic pushed;

   // no boundary in the cycle after a push, while the load runs, so a second accept waits for the load
   assign core_boundary = run & ~pushed;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pushed <= 1'b0;
         depth <= 4'h0;
         pc <= 16'h0000;
         seq_err <= 1'b0;
         core_reti <= 1'b0;
      end else begin
         pushed <= push_pc;
         // a return with an empty stack would be a bench slip, so it is dropped
         core_reti <= ret_req & (depth != 4'h0);
         depth <= depth + {3'h0, push_pc} - {3'h0, core_reti};
         // a load that is not preceded by a push loses the return address
         if (load_pc & ~pushed) begin
            seq_err <= 1'b1;
         end
         if (load_pc) begin
            pc <= dispatch.vector;
         end
      end
   end
endmodule

// ### two_level_irq_priority_tb_top.sv
// self-checking bench for the two-level interrupt controller
`timescale 1ns/1ps
module two_level_irq_priority_tb_top;
   import irq_pkg::*;
   localparam int TIMEOUT = 20000;
   localparam logic [15:0] VEC [11] = '{16'h0043, 16'h005B, 16'h0003, 16'h0033, 16'h000B, 16'h0013,
      16'h001B, 16'h003B, 16'h0023, 16'h002B, 16'h0053};
   logic mclk, rst, sfr_wr, sfr_rd, global_enable, alt, master_mode, clock_phase;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
   prim_bits_t pen, plv;
   logic [10:0] flags;
   logic master_byte_done, slave_eighth_clock, ss_n, sclr, sdone, irq_pending, push_pc, load_pc;
   logic ish, isl, run, ret_req, seq_err, core_boundary, core_reti;
   dispatch_t dispatch;
   logic [15:0] pc;
   logic [3:0] depth;
   int errors, checks_done, cycles;

   two_level_irq_priority i_two_level_irq_priority (.mclk(mclk), .rst(rst), .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .global_enable(global_enable), .primary_enable(pen), .primary_level(plv),
      .supply_monitor_request(flags[0]), .watchdog_request(flags[1]), .external_zero_request(flags[2]),
      .converter_ready_flags({flags[3] & alt, flags[3] & ~alt}), .timer_zero_overflow(flags[4]),
      .external_one_request(flags[5]), .timer_one_overflow(flags[6]), .two_wire_done_flag(flags[7]),
      .uart_rx_tx_flags({flags[8] & alt, flags[8] & ~alt}), .timer_two_overflow(flags[9] & ~alt),
      .timer_two_external_flag(flags[9] & alt), .interval_counter_request(flags[10]),
      .master_mode(master_mode), .clock_phase(clock_phase), .master_byte_done(master_byte_done),
      .slave_eighth_clock(slave_eighth_clock), .slave_select_n_pin(ss_n), .serial_flag_clear(sclr),
      .serial_periph_done_flag(sdone), .core_boundary(core_boundary), .core_reti(core_reti),
      .irq_pending(irq_pending), .push_pc(push_pc), .load_pc(load_pc), .dispatch(dispatch),
      .in_service_high(ish), .in_service_low(isl));

   core_model i_core_model (.mclk(mclk), .rst(rst), .push_pc(push_pc), .load_pc(load_pc),
      .dispatch(dispatch), .core_boundary(core_boundary), .core_reti(core_reti), .run(run),
      .ret_req(ret_req), .pc(pc), .depth(depth), .seq_err(seq_err));

   // ---------------------------------------------------------------
   // clock, reset and hang guard
   // ---------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      cycles++;
      if (cycles == TIMEOUT) begin
         errors++;
         conclude();
      end
   end

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic tick();
      @(posedge mclk);
      #1;
   endtask

   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp, input string what);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask

   task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      tick();
      sfr_wr = 1'b0;
      tick();
   endtask

   task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
      sfr_addr = a;
      sfr_rd = 1'b1;
      tick();
      sfr_rd = 1'b0;
      d = sfr_rdata;
      tick();
      chk_val({8'h00, sfr_rdata}, 16'h0000, "read data after its cycle");
   endtask

   // waits for an accept and follows it through push and load
   task automatic take(input int src, input logic lvl);
      int n;
      n = 0;
      while (push_pc !== 1'b1 && n < 20) begin
         tick();
         n++;
      end
      chk_bit(push_pc, 1'b1, "push");
      chk_bit(load_pc, 1'b0, "load with push");
      chk_val({12'h000, dispatch.src}, 16'(src), "source");
      chk_val(dispatch.vector, VEC[src], "vector");
      chk_bit(dispatch.level, lvl, "level");
      tick();
      chk_bit(load_pc, 1'b1, "load");
      chk_bit(lvl ? ish : isl, 1'b1, "in service");
      tick();
      chk_val(pc, VEC[src], "core pc");
   endtask

   task automatic serve(input int src);
      flags[src] = 1'b0;
      ret_req = 1'b1;
      tick();
      ret_req = 1'b0;
      tick();
      tick();
   endtask

   task automatic none(input int n);
      repeat (n) begin
         tick();
         chk_bit(push_pc, 1'b0, "no accept");
      end
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_regs();
      logic [7:0] d;
      sfr_read(8'hA9, d);
      chk_val({8'h00, d}, 16'h00A0, "power-up value");
      sfr_read(8'hA8, d);
      chk_val({8'h00, d}, 16'h0000, "unmapped read");
      sfr_write(8'hA9, 8'h77);
      sfr_read(8'hA9, d);
      chk_val({8'h00, d}, 16'h00F7, "enable and level bits");
      sfr_write(8'hA9, 8'h00);
      sfr_read(8'hA9, d);
      chk_val({8'h00, d}, 16'h0080, "top bit ignores writes");
   endtask

   // all eleven raised in one cycle, served one by one; second pass uses the other ADC, UART and t2 flags
   task automatic t_poll();
      pen = prim_bits_t'(8'hFF);
      plv = prim_bits_t'(8'h00);
      sfr_write(8'hA9, 8'h07);
      global_enable = 1'b1;
      for (int a = 0; a < 2; a++) begin
         alt = a[0];
         flags = 11'h7FF;
         for (int i = 0; i < 11; i++) begin
            take(i, 1'b0);
            serve(i);
         end
      end
   endtask

   task automatic t_gate();
      pen = prim_bits_t'(8'h00);
      flags[2] = 1'b1;
      none(6);
      pen = prim_bits_t'(8'h40);
      global_enable = 1'b0;
      none(6);
      run = 1'b0;
      global_enable = 1'b1;
      tick();
      tick();
      chk_bit(irq_pending, 1'b1, "pending");
      run = 1'b1;
      take(2, 1'b0);
      serve(2);
      sfr_write(8'hA9, 8'h05);
      flags[0] = 1'b1;
      none(6);
      sfr_write(8'hA9, 8'h07);
      take(0, 1'b0);
      serve(0);
   endtask

   task automatic t_prio();
      pen = prim_bits_t'(8'hFF);
      plv = prim_bits_t'(8'h04);
      flags[0] = 1'b1;
      flags[6] = 1'b1;
      take(6, 1'b1);
      none(6);
      serve(6);
      take(0, 1'b0);
      flags[2] = 1'b1;
      none(6);
      flags[6] = 1'b1;
      take(6, 1'b1);
      chk_val({12'h000, depth}, 16'h0002, "nested depth");
      serve(6);
      none(4);
      flags[2] = 1'b0;
      serve(0);
      plv = prim_bits_t'(8'h00);
      sfr_write(8'hA9, 8'h47);
      flags[10] = 1'b1;
      flags[2] = 1'b1;
      take(10, 1'b1);
      serve(10);
      take(2, 1'b0);
      serve(2);
   endtask

   task automatic t_serial();
      int n;
      global_enable = 1'b0;
      master_mode = 1'b1;
      master_byte_done = 1'b1;
      tick();
      master_byte_done = 1'b0;
      chk_bit(sdone, 1'b1, "master done");
      master_byte_done = 1'b1;
      sclr = 1'b1;
      tick();
      master_byte_done = 1'b0;
      chk_bit(sdone, 1'b1, "set beats clear");
      sclr = 1'b1;
      tick();
      sclr = 1'b0;
      chk_bit(sdone, 1'b0, "flag cleared");
      master_mode = 1'b0;
      clock_phase = 1'b0;
      slave_eighth_clock = 1'b1;
      tick();
      slave_eighth_clock = 1'b0;
      tick();
      chk_bit(sdone, 1'b0, "phase 0 waits for select");
      ss_n = 1'b0;
      repeat (3) tick();
      ss_n = 1'b1;
      n = 0;
      while (sdone !== 1'b1 && n < 8) begin
         tick();
         n++;
      end
      chk_bit(sdone, 1'b1, "select release");
      sclr = 1'b1;
      tick();
      sclr = 1'b0;
      clock_phase = 1'b1;
      slave_eighth_clock = 1'b1;
      tick();
      slave_eighth_clock = 1'b0;
      chk_bit(sdone, 1'b1, "eighth clock");
      global_enable = 1'b1;
      take(7, 1'b0);
      sclr = 1'b1;
      tick();
      sclr = 1'b0;
      serve(7);
   endtask

   task automatic conclude();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      {sfr_wr, sfr_rd, global_enable, alt, master_mode, clock_phase} = '0;
      {master_byte_done, slave_eighth_clock, sclr, ret_req} = '0;
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      pen = prim_bits_t'(8'h00);
      plv = prim_bits_t'(8'h00);
      flags = 11'h000;
      ss_n = 1'b1;
      run = 1'b1;
      rst = 1'b1;
      repeat (20) @(posedge mclk);
      #1;
      rst = 1'b0;
      tick();
      t_regs();
      t_poll();
      t_gate();
      t_prio();
      t_serial();
      chk_bit(seq_err, 1'b0, "push before load");
      conclude();
   end
endmodule
